// ===== cell_phy_end.sv
// Purpose: PHY end of the cell port, slave to the ATM layer.
// Assumes: User side runs on the link clocks it belongs to.
// Notes:   Reset and static settings are synchronised into each domain.
`timescale 1ns/100ps
module cell_phy_end
  import cell_port_pkg::*;
(
  cell_link_if.phy         link,
  input  wire logic        sys_rst,
  input  wire logic        wide_mode,
  input  wire logic        odd_parity,
  // Transmit side, on cell_in_clock
  input  wire logic        in_room,
  output      logic [15:0] in_word,
  output      logic        in_first,
  output      logic        in_last,
  output      logic        in_valid,
  output      logic        in_par_err,
  // Receive side, on cell_out_clock
  input  wire logic        out_avail,
  input  wire logic [15:0] out_word,
  input  wire logic        out_first,
  input  wire logic        out_valid,
  output      logic        out_take
);

  typedef enum logic {IN_IDLE, IN_CELL} in_state_t;

  // Transmit domain state
  logic        rst_in_meta_ff;
  logic        rst_in_ff;
  logic [1:0]  cfg_in_meta_ff;
  logic [1:0]  cfg_in_ff;
  logic        sel_in_ff;
  logic        room_o_ff;
  logic        room_oe_n_ff;
  in_state_t   in_state_ff;
  logic [5:0]  in_cnt_ff;
  logic [15:0] in_word_ff;
  logic        in_first_ff;
  logic        in_last_ff;
  logic        in_valid_ff;
  logic        in_par_err_ff;
  logic        in_take;
  logic        in_addr_hit;
  logic [15:0] in_data;

  // Receive domain state
  logic        rst_out_meta_ff;
  logic        rst_out_ff;
  logic [1:0]  cfg_out_meta_ff;
  logic [1:0]  cfg_out_ff;
  logic        sel_out_ff;
  logic        ready_o_ff;
  logic        ready_oe_n_ff;
  logic [15:0] out_bus_ff;
  logic        out_soc_ff;
  logic        out_par_ff;
  logic        out_oe_n_ff;
  logic        out_drive;
  logic        out_addr_hit;
  logic [15:0] out_data;

  // Reset and settings brought into the transmit domain
  always_ff @(posedge link.cell_in_clock)
  begin
    rst_in_meta_ff <= sys_rst;
    rst_in_ff      <= rst_in_meta_ff;
  end

  // Width and parity settings are static, sampled twice
  always_ff @(posedge link.cell_in_clock)
  begin
    cfg_in_meta_ff <= {wide_mode, odd_parity};
    cfg_in_ff      <= cfg_in_meta_ff;
  end

  // Port select match against the own address
  assign in_addr_hit = (link.cell_in_port_select == OWN_PORT_ADDR);

  // A word is taken only when enabled and this port is selected
  assign in_take = !link.cell_in_enable_n && sel_in_ff;
  assign in_data = lane_mask(link.cell_in_bus, cfg_in_ff[1]);

  // Selection follows the address seen while enable is high
  always_ff @(posedge link.cell_in_clock)
  begin
    if (rst_in_ff)
      sel_in_ff <= 1'b0;
    else if (link.cell_in_enable_n)
      sel_in_ff <= in_addr_hit;
  end

  // Cell-available answered in the cycle after a matching poll
  always_ff @(posedge link.cell_in_clock)
  begin
    if (rst_in_ff)
    begin
      room_o_ff    <= 1'b0;
      room_oe_n_ff <= 1'b1;
    end
    else
    begin
      room_o_ff    <= in_room;
      room_oe_n_ff <= !in_addr_hit;
    end
  end

  // Cell framing: wait for first word, then count the cell out
  always_ff @(posedge link.cell_in_clock)
  begin
    if (rst_in_ff)
    begin
      in_state_ff <= IN_IDLE;
      in_cnt_ff   <= 6'h00;
    end
    else if (in_take)
    begin
      unique case (in_state_ff)
        IN_IDLE:
        begin
          if (link.cell_in_first_word)
          begin
            in_state_ff <= IN_CELL;
            in_cnt_ff   <= 6'h01;
          end
        end
        IN_CELL:
        begin
          if (in_cnt_ff == cell_len(cfg_in_ff[1]) - 6'h01)
          begin
            in_state_ff <= IN_IDLE;
            in_cnt_ff   <= 6'h00;
          end
          else
            in_cnt_ff <= in_cnt_ff + 6'h01;
        end
      endcase
    end
  end

  // Captured words toward the user; stray words are dropped
  always_ff @(posedge link.cell_in_clock)
  begin
    if (rst_in_ff)
    begin
      in_word_ff    <= 16'h0000;
      in_first_ff   <= 1'b0;
      in_last_ff    <= 1'b0;
      in_valid_ff   <= 1'b0;
      in_par_err_ff <= 1'b0;
    end
    else
    begin
      in_valid_ff   <= 1'b0;
      in_par_err_ff <= 1'b0;
      if (in_take && (in_state_ff == IN_CELL || link.cell_in_first_word))
      begin
        in_word_ff    <= in_data;
        in_first_ff   <= (in_state_ff == IN_IDLE);
        in_last_ff    <= (in_state_ff == IN_CELL) &&
                         (in_cnt_ff == cell_len(cfg_in_ff[1]) - 6'h01);
        in_valid_ff   <= 1'b1;
        in_par_err_ff <= link.cell_in_parity !=
                         word_parity(link.cell_in_bus, cfg_in_ff[1],
                                     cfg_in_ff[0]);
      end
    end
  end

  assign in_word    = in_word_ff;
  assign in_first   = in_first_ff;
  assign in_last    = in_last_ff;
  assign in_valid   = in_valid_ff;
  assign in_par_err = in_par_err_ff;
  assign link.cell_in_room_o    = room_o_ff;
  assign link.cell_in_room_oe_n = room_oe_n_ff;

  // Reset and settings brought into the receive domain
  always_ff @(posedge link.cell_out_clock)
  begin
    rst_out_meta_ff <= sys_rst;
    rst_out_ff      <= rst_out_meta_ff;
  end

  // Width and parity settings are static, sampled twice
  always_ff @(posedge link.cell_out_clock)
  begin
    cfg_out_meta_ff <= {wide_mode, odd_parity};
    cfg_out_ff      <= cfg_out_meta_ff;
  end

  // Port select match against the own address
  assign out_addr_hit = (link.cell_out_port_select == OWN_PORT_ADDR);

  // Selection follows the address seen while enable is high
  always_ff @(posedge link.cell_out_clock)
  begin
    if (rst_out_ff)
      sel_out_ff <= 1'b0;
    else if (link.cell_out_enable_n)
      sel_out_ff <= out_addr_hit;
  end

  // Enable sampled low while selected asks for one word
  assign out_drive = !link.cell_out_enable_n && sel_out_ff;
  assign out_take  = out_drive && out_valid;
  assign out_data  = lane_mask(out_word, cfg_out_ff[1]);

  // Cell-available answered in the cycle after a matching poll
  always_ff @(posedge link.cell_out_clock)
  begin
    if (rst_out_ff)
    begin
      ready_o_ff    <= 1'b0;
      ready_oe_n_ff <= 1'b1;
    end
    else
    begin
      ready_o_ff    <= out_avail;
      ready_oe_n_ff <= !out_addr_hit;
    end
  end

  // Bus drive window: one cycle after each selected enable cycle
  always_ff @(posedge link.cell_out_clock)
  begin
    if (rst_out_ff)
      out_oe_n_ff <= 1'b1;
    else
      out_oe_n_ff <= !out_drive;
  end

  // Word, first flag and parity change just after the clock rise
  always_ff @(posedge link.cell_out_clock)
  begin
    if (rst_out_ff)
    begin
      out_bus_ff <= 16'h0000;
      out_soc_ff <= 1'b0;
      out_par_ff <= 1'b0;
    end
    else if (out_drive)
    begin
      out_bus_ff <= out_data;
      out_soc_ff <= out_valid && out_first;
      out_par_ff <= word_parity(out_data, cfg_out_ff[1],
                                cfg_out_ff[0]);
    end
  end

  assign link.cell_out_bus_o        = out_bus_ff;
  assign link.cell_out_first_word_o = out_soc_ff;
  assign link.cell_out_parity_o     = out_par_ff;
  assign link.cell_out_drive_oe_n   = out_oe_n_ff;
  assign link.cell_out_ready_o      = ready_o_ff;
  assign link.cell_out_ready_oe_n   = ready_oe_n_ff;

endmodule

// ===== cell_port_pkg.sv
// Purpose: Shared constants and helpers for the cell transfer port.
// Assumes: Both ends compile this package first.
// Notes:   Half-period of the link clock is counted in core_clk cycles.
// Contract
// - PHY captures transmit bus on clock rise.
// - ATM drives transmit enable low only with data.
// - PHY gives tri-stateable transmit cell-available flag.
// - ATM drives five-bit transmit port select.
// - Receive bus is 16 or 8 bits wide.
// - Receive bus driven only when enabled and selected.
// - PHY generates odd or even receive parity.
// - PHY flags first word of each receive cell.
// - Receive outputs change after receive clock rise.
// - Receive data valid end of cycle after enable.
// - Receive outputs enabled only after enable cycles.
// - ATM toggles receive enable high between transfers.
// - PHY gives tri-stateable receive cell-available flag.
// - ATM drives five-bit receive port select.
// - Cell is 27 words or 53 bytes.
// - After a cell, wait for fresh first word.
// - Ignore transmit data between cells.
// - PHY samples transmit parity on clock rise.
package cell_port_pkg;

  localparam int          DATA_W        = 16;
  localparam int          ADDR_W        = 5;
  localparam int          CNT_W         = 6;
  localparam logic [5:0]  WORDS_WIDE    = 6'h1b;  // 27 words of 16 bits
  localparam logic [5:0]  BYTES_NARROW  = 6'h35;  // 53 bytes
  localparam logic [4:0]  OWN_PORT_ADDR = 5'h00;  // PHY address of this port
  localparam logic [2:0]  LINK_HALF     = 3'h4;   // Core cycles per half

  // Cell length in transfers for the chosen width
  function automatic logic [5:0] cell_len(input logic wide);
    cell_len = wide ? WORDS_WIDE : BYTES_NARROW;
  endfunction

  // Keeps the low byte only in narrow mode
  function automatic logic [15:0] lane_mask(input logic [15:0] d,
                                             input logic        wide);
    lane_mask = wide ? d : {8'h00, d[7:0]};
  endfunction

  // Parity bit over the active lanes, odd or even
  function automatic logic word_parity(input logic [15:0] d,
                                       input logic        wide,
                                       input logic        odd);
    word_parity = (^lane_mask(d, wide)) ^ odd;
  endfunction

endpackage

// ===== cell_link_if.sv
// Purpose: Pins between the ATM layer end and the PHY end.
// Assumes: Undriven tri-state lines read as zero (weak pull-down).
// Notes:   Output enables are active low.
`timescale 1ns/100ps
interface cell_link_if;
  // Transmit direction, driven by the ATM layer
  logic        cell_in_clock;
  logic        cell_in_enable_n;
  logic [4:0]  cell_in_port_select;
  logic [15:0] cell_in_bus;
  logic        cell_in_first_word;
  logic        cell_in_parity;
  // Transmit cell-available, driven by the PHY
  logic        cell_in_room_o;
  logic        cell_in_room_oe_n;
  logic        cell_in_room_flag;
  // Receive direction, driven by the ATM layer
  logic        cell_out_clock;
  logic        cell_out_enable_n;
  logic [4:0]  cell_out_port_select;
  // Receive outputs, driven by the PHY
  logic [15:0] cell_out_bus_o;
  logic        cell_out_first_word_o;
  logic        cell_out_parity_o;
  logic        cell_out_drive_oe_n;
  logic        cell_out_ready_o;
  logic        cell_out_ready_oe_n;
  logic [15:0] cell_out_bus;
  logic        cell_out_first_word;
  logic        cell_out_parity;
  logic        cell_out_ready_flag;

  // Wire levels resolved from the enables
  assign cell_in_room_flag   = !cell_in_room_oe_n && cell_in_room_o;
  assign cell_out_ready_flag = !cell_out_ready_oe_n && cell_out_ready_o;
  assign cell_out_bus        = cell_out_drive_oe_n ? 16'h0000
                                                   : cell_out_bus_o;
  assign cell_out_first_word = !cell_out_drive_oe_n && cell_out_first_word_o;
  assign cell_out_parity     = !cell_out_drive_oe_n && cell_out_parity_o;

  modport phy (
    input  cell_in_clock, cell_in_enable_n, cell_in_port_select,
    input  cell_in_bus, cell_in_first_word, cell_in_parity,
    output cell_in_room_o, cell_in_room_oe_n,
    input  cell_out_clock, cell_out_enable_n, cell_out_port_select,
    output cell_out_bus_o, cell_out_first_word_o, cell_out_parity_o,
    output cell_out_drive_oe_n, cell_out_ready_o, cell_out_ready_oe_n
  );

  modport atm (
    output cell_in_clock, cell_in_enable_n, cell_in_port_select,
    output cell_in_bus, cell_in_first_word, cell_in_parity,
    input  cell_in_room_flag,
    output cell_out_clock, cell_out_enable_n, cell_out_port_select,
    input  cell_out_bus, cell_out_first_word, cell_out_parity,
    input  cell_out_ready_flag
  );
endinterface

// ===== cell_atm_end.sv
// Purpose: ATM layer end, master of both link directions.
// Assumes: Link clocks come from core_clk by a divide-by-eight.
// Notes:   Pins are driven on the link clock fall, read after sync.
`timescale 1ns/100ps
module cell_atm_end
  import cell_port_pkg::*;
(
  cell_link_if.atm         link,
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic        wide_mode,
  input  wire logic        odd_parity,
  input  wire logic [4:0]  tx_target,
  input  wire logic [15:0] tx_word,
  input  wire logic        tx_first,
  input  wire logic        tx_valid,
  output      logic        tx_take,
  input  wire logic [4:0]  rx_target,
  output      logic [15:0] rx_word,
  output      logic        rx_first,
  output      logic        rx_valid,
  output      logic        rx_par_err
);

  typedef enum logic {T_POLL, T_SEND} tx_state_t;
  typedef enum logic {R_POLL, R_GET} rx_state_t;

  logic [2:0]  phase_ff;
  logic        clk_ff;
  logic        fall_pt;
  logic [3:0]  rst_age_ff;
  logic        div_run;
  logic [19:0] pin_meta_ff;
  logic [19:0] pin_ff;
  tx_state_t   tx_state_ff;
  logic [5:0]  tx_cnt_ff;
  logic        tx_enb_n_ff;
  logic [15:0] tx_bus_ff;
  logic        tx_soc_ff;
  logic        tx_par_ff;
  logic        tx_start;
  rx_state_t   rx_state_ff;
  logic [5:0]  rx_cnt_ff;
  logic        rx_enb_n_ff;
  logic [15:0] rx_word_ff;
  logic        rx_first_ff;
  logic        rx_valid_ff;
  logic        rx_par_err_ff;

  // Age of the reset; the divider halts only early in a reset
  always_ff @(posedge core_clk)
  begin
    rst_age_ff <= {rst_age_ff[2:0], sys_rst};
  end

  // Clock runs through late reset so the PHY end sees sys_rst
  assign div_run = !sys_rst || rst_age_ff[3];

  // Link clock divider; an unknown age falls to the halt branch
  always_ff @(posedge core_clk)
  begin
    if (div_run)
    begin
      phase_ff <= phase_ff + 3'h1;
      clk_ff   <= (phase_ff + 3'h1) < LINK_HALF;
    end
    else
    begin
      phase_ff <= 3'h0;
      clk_ff   <= 1'b0;
    end
  end

  assign fall_pt = (phase_ff == LINK_HALF - 3'h1);

  // Device outputs pass two flip-flops
  always_ff @(posedge core_clk)
  begin
    pin_meta_ff <= {link.cell_in_room_flag, link.cell_out_ready_flag,
                    link.cell_out_first_word, link.cell_out_parity,
                    link.cell_out_bus};
    pin_ff      <= pin_meta_ff;
  end

  // A cell starts after a high enable cycle and room seen
  assign tx_start = (tx_state_ff == T_POLL) && tx_enb_n_ff && pin_ff[19] &&
                    tx_valid && tx_first;
  assign tx_take  = !sys_rst && fall_pt && tx_valid &&
                    (tx_start || tx_state_ff == T_SEND ||
                     (tx_state_ff == T_POLL && !tx_first));

  // Transmit sequencing, updated at each link clock fall
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      tx_state_ff <= T_POLL;
      tx_cnt_ff   <= 6'h00;
      tx_enb_n_ff <= 1'b1;
      tx_bus_ff   <= 16'h0000;
      tx_soc_ff   <= 1'b0;
      tx_par_ff   <= 1'b0;
    end
    else if (fall_pt)
    begin
      tx_enb_n_ff <= 1'b1;
      tx_soc_ff   <= 1'b0;
      if (tx_start || (tx_state_ff == T_SEND && tx_valid))
      begin
        tx_enb_n_ff <= 1'b0;
        tx_bus_ff   <= lane_mask(tx_word, wide_mode);
        tx_soc_ff   <= tx_start;
        tx_par_ff   <= word_parity(tx_word, wide_mode, odd_parity);
        if (tx_start)
        begin
          tx_state_ff <= T_SEND;
          tx_cnt_ff   <= 6'h01;
        end
        else if (tx_cnt_ff == cell_len(wide_mode) - 6'h01)
          tx_state_ff <= T_POLL;
        else
          tx_cnt_ff <= tx_cnt_ff + 6'h01;
      end
    end
  end

  // Receive sequencing: poll, then request one full cell
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      rx_state_ff <= R_POLL;
      rx_cnt_ff   <= 6'h00;
      rx_enb_n_ff <= 1'b1;
    end
    else if (fall_pt)
    begin
      unique case (rx_state_ff)
        R_POLL:
        begin
          if (rx_enb_n_ff && pin_ff[18])
          begin
            rx_enb_n_ff <= 1'b0;
            rx_state_ff <= R_GET;
            rx_cnt_ff   <= 6'h01;
          end
        end
        R_GET:
        begin
          if (rx_cnt_ff == cell_len(wide_mode))
          begin
            rx_enb_n_ff <= 1'b1;
            rx_state_ff <= R_POLL;
          end
          else
            rx_cnt_ff <= rx_cnt_ff + 6'h01;
        end
      endcase
    end
  end

  // Word captured one link cycle after each low enable
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      rx_word_ff    <= 16'h0000;
      rx_first_ff   <= 1'b0;
      rx_valid_ff   <= 1'b0;
      rx_par_err_ff <= 1'b0;
    end
    else
    begin
      rx_valid_ff <= fall_pt && !rx_enb_n_ff;
      if (fall_pt && !rx_enb_n_ff)
      begin
        rx_word_ff    <= lane_mask(pin_ff[15:0], wide_mode);
        rx_first_ff   <= pin_ff[17];
        rx_par_err_ff <= pin_ff[16] !=
                         word_parity(pin_ff[15:0], wide_mode, odd_parity);
      end
    end
  end

  assign link.cell_in_clock        = clk_ff;
  assign link.cell_out_clock       = clk_ff;
  assign link.cell_in_enable_n     = tx_enb_n_ff;
  assign link.cell_in_port_select  = tx_target;
  assign link.cell_in_bus          = tx_bus_ff;
  assign link.cell_in_first_word   = tx_soc_ff;
  assign link.cell_in_parity       = tx_par_ff;
  assign link.cell_out_enable_n    = rx_enb_n_ff;
  assign link.cell_out_port_select = rx_target;
  assign rx_word    = rx_word_ff;
  assign rx_first   = rx_first_ff;
  assign rx_valid   = rx_valid_ff;
  assign rx_par_err = rx_par_err_ff;

endmodule

// ===== cell_port_properties.sv
// Purpose: Pin-level checks on the link between the two ends.
// Assumes: Sampled on the link clock rise; sys_rst is active high.
// Notes:   Counters track the word position inside each cell.
`timescale 1ns/100ps
module cell_port_properties
  import cell_port_pkg::*;
(
  input wire logic        cell_in_clock,
  input wire logic        sys_rst,
  input wire logic        wide_mode,
  input wire logic        odd_parity,
  input wire logic        cell_in_enable_n,
  input wire logic [4:0]  cell_in_port_select,
  input wire logic [15:0] cell_in_bus,
  input wire logic        cell_in_first_word,
  input wire logic        cell_in_parity,
  input wire logic        cell_in_room_oe_n,
  input wire logic        cell_in_room_flag,
  input wire logic        cell_out_enable_n,
  input wire logic [4:0]  cell_out_port_select,
  input wire logic [15:0] cell_out_bus,
  input wire logic        cell_out_first_word,
  input wire logic        cell_out_parity,
  input wire logic        cell_out_drive_oe_n,
  input wire logic        cell_out_ready_oe_n
);
  logic [5:0] len;
  logic [5:0] tx_pos_ff;
  logic [5:0] rx_pos_ff;
  logic [5:0] low_run_ff;
  logic       tx_par;
  logic       rx_par;

  // Cell length and expected parity over the active lanes
  assign len    = wide_mode ? WORDS_WIDE : BYTES_NARROW;
  assign tx_par = (wide_mode ? ^cell_in_bus : ^cell_in_bus[7:0]) ^ odd_parity;
  assign rx_par = (wide_mode ? ^cell_out_bus : ^cell_out_bus[7:0]) ^ odd_parity;

  // Position of the next transmit word in its cell
  always_ff @(posedge cell_in_clock)
  begin
    if (sys_rst)
      tx_pos_ff <= 6'h00;
    else if (!cell_in_enable_n)
      tx_pos_ff <= (tx_pos_ff == len - 6'h01) ? 6'h00 : tx_pos_ff + 6'h01;
  end

  // Position of the next driven receive word in its cell
  always_ff @(posedge cell_in_clock)
  begin
    if (sys_rst)
      rx_pos_ff <= 6'h00;
    else if (!cell_out_drive_oe_n)
      rx_pos_ff <= (rx_pos_ff == len - 6'h01) ? 6'h00 : rx_pos_ff + 6'h01;
  end

  // Length of the current run of receive requests
  always_ff @(posedge cell_in_clock)
  begin
    if (sys_rst || cell_out_enable_n)
      low_run_ff <= 6'h00;
    else
      low_run_ff <= low_run_ff + 6'h01;
  end

  default clocking cb @(posedge cell_in_clock);
  endclocking
  default disable iff (sys_rst);

  rx_drive_cause_a:
    assert property (!cell_out_drive_oe_n |-> !$past(cell_out_enable_n)
      && $past(cell_out_port_select) == OWN_PORT_ADDR)
    else $error("receive bus driven without a request");
  rx_answer_due_a:
    assert property (!cell_out_enable_n
      && cell_out_port_select == OWN_PORT_ADDR |=> !cell_out_drive_oe_n)
    else $error("receive request not answered next cycle");
  rx_parity_ok_a:
    assert property (!cell_out_drive_oe_n |-> cell_out_parity == rx_par)
    else $error("receive parity wrong");
  rx_first_word_a:
    assert property (!cell_out_drive_oe_n
      |-> cell_out_first_word == (rx_pos_ff == 6'h00))
    else $error("receive start of cell misplaced");
  tx_first_word_a:
    assert property (!cell_in_enable_n
      |-> cell_in_first_word == (tx_pos_ff == 6'h00))
    else $error("transmit start of cell misplaced");
  tx_parity_ok_a:
    assert property (!cell_in_enable_n |-> cell_in_parity == tx_par)
    else $error("transmit parity wrong");
  tx_room_owner_a:
    assert property (!cell_in_room_oe_n
      |-> $past(cell_in_port_select) == OWN_PORT_ADDR)
    else $error("transmit flag driven for another address");
  rx_ready_owner_a:
    assert property (!cell_out_ready_oe_n
      |-> $past(cell_out_port_select) == OWN_PORT_ADDR)
    else $error("receive flag driven for another address");
  rx_enable_break_a:
    assert property (low_run_ff <= len)
    else $error("receive enable held low past one cell");

  cover property (!cell_out_drive_oe_n && cell_out_first_word);
  cover property (!cell_in_enable_n && cell_in_first_word && !wide_mode);
  cover property (cell_in_room_flag);
endmodule

// ===== utopia_mphy_slave_port_tb.sv
// Purpose: Self-checking bench joining the ATM end to the PHY end.
// Assumes: The link clock is divided from core_clk by the ATM end.
// Notes:   Each run resets with new settings; the four rows carry two cells each way, then a no-room and a wrong-address run.
`timescale 1ns/100ps
module utopia_mphy_slave_port_tb
  import cell_port_pkg::*;
;
  typedef struct packed {
    logic       wide;
    logic       odd;
    logic [7:0] tb;
    logic [7:0] rb;
    logic [7:0] n;
  } row_t;

  logic        core_clk   = 1'b0;
  logic        sys_rst    = 1'b1;
  logic        wide_mode  = 1'b1;
  logic        odd_parity = 1'b0;
  logic [4:0]  tx_target  = 5'h00;
  logic [4:0]  rx_target  = 5'h00;
  logic [15:0] tx_word    = 16'h0000;
  logic        tx_first   = 1'b0;
  logic        tx_valid   = 1'b0;
  logic        in_room    = 1'b1;
  logic [15:0] out_word   = 16'h0000;
  logic        out_first  = 1'b0;
  logic        out_valid  = 1'b0;
  logic        out_avail  = 1'b0;
  logic [7:0]  tx_base    = 8'h00;
  logic [7:0]  rx_base    = 8'h00;
  logic [15:0] rx_word;
  logic [15:0] in_word;
  logic        tx_take;
  logic        rx_first;
  logic        rx_valid;
  logic        rx_par_err;
  logic        in_first;
  logic        in_last;
  logic        in_valid;
  logic        in_par_err;
  logic        out_take;
  int          tx_sent;
  int          rx_fed;
  int          in_cnt;
  int          rx_cnt;
  int          goal;
  int          cyc;
  int          err_total;
  int          check_count;
  row_t        rows [4] = '{'{1'b1, 1'b0, 8'h3c, 8'ha5, 8'h36},
                            '{1'b1, 1'b1, 8'h5a, 8'hc3, 8'h36},
                            '{1'b0, 1'b0, 8'h96, 8'h69, 8'h6a},
                            '{1'b0, 1'b1, 8'he1, 8'h1e, 8'h6a}};

  cell_link_if link ();

  cell_atm_end i_cell_atm_end (.link(link), .core_clk(core_clk),
    .sys_rst(sys_rst), .wide_mode(wide_mode), .odd_parity(odd_parity),
    .tx_target(tx_target), .tx_word(tx_word), .tx_first(tx_first),
    .tx_valid(tx_valid), .tx_take(tx_take), .rx_target(rx_target),
    .rx_word(rx_word), .rx_first(rx_first), .rx_valid(rx_valid),
    .rx_par_err(rx_par_err));

  cell_phy_end i_cell_phy_end (.link(link), .sys_rst(sys_rst),
    .wide_mode(wide_mode), .odd_parity(odd_parity), .in_room(in_room),
    .in_word(in_word), .in_first(in_first), .in_last(in_last),
    .in_valid(in_valid), .in_par_err(in_par_err), .out_avail(out_avail),
    .out_word(out_word), .out_first(out_first), .out_valid(out_valid),
    .out_take(out_take));

  cell_port_properties i_cell_port_properties (
    .cell_in_clock(link.cell_in_clock), .sys_rst(sys_rst),
    .wide_mode(wide_mode), .odd_parity(odd_parity),
    .cell_in_enable_n(link.cell_in_enable_n),
    .cell_in_port_select(link.cell_in_port_select),
    .cell_in_bus(link.cell_in_bus),
    .cell_in_first_word(link.cell_in_first_word),
    .cell_in_parity(link.cell_in_parity),
    .cell_in_room_oe_n(link.cell_in_room_oe_n),
    .cell_in_room_flag(link.cell_in_room_flag),
    .cell_out_enable_n(link.cell_out_enable_n),
    .cell_out_port_select(link.cell_out_port_select),
    .cell_out_bus(link.cell_out_bus),
    .cell_out_first_word(link.cell_out_first_word),
    .cell_out_parity(link.cell_out_parity),
    .cell_out_drive_oe_n(link.cell_out_drive_oe_n),
    .cell_out_ready_oe_n(link.cell_out_ready_oe_n));

  always #50 core_clk = ~core_clk;

  function automatic int clen();
    clen = wide_mode ? int'(WORDS_WIDE) : int'(BYTES_NARROW);
  endfunction

  function automatic logic [15:0] pat(input logic [7:0] b, input int i);
    pat = {b, 8'(i % clen())};
  endfunction

  function automatic logic [15:0] lane(input logic [15:0] w);
    lane = wide_mode ? w : {8'h00, w[7:0]};
  endfunction

  task automatic chk(input string nm, input logic [19:0] e,
                     input logic [19:0] g);
    check_count++;
    if (g !== e)
    begin
      err_total++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic finish_test();
    if (err_total == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Transmit stream into the ATM end, two cells back to back
  always @(posedge core_clk)
    if (tx_valid && tx_take)
    begin
      tx_sent <= tx_sent + 1;
      tx_word <= pat(tx_base, tx_sent + 1);
      tx_first <= ((tx_sent + 1) % clen() == 0);
      tx_valid <= (tx_sent + 1 < goal);
    end

  // Cells offered to the PHY end for the receive direction
  always @(posedge link.cell_out_clock)
    if (out_valid && out_take)
    begin
      rx_fed <= rx_fed + 1;
      out_word <= pat(rx_base, rx_fed + 1);
      out_first <= ((rx_fed + 1) % clen() == 0);
      out_valid <= (rx_fed + 1 < goal);
      out_avail <= (rx_fed + 1 < goal);
    end

  // Words delivered by the PHY end
  always @(posedge link.cell_in_clock)
    if (in_valid === 1'b1)
    begin
      chk("in", {1'b0, in_cnt % clen() == 0, in_cnt % clen() == clen() - 1,
        1'b0, lane(pat(tx_base, in_cnt))},
        {1'b0, in_first, in_last, in_par_err, lane(in_word)});
      in_cnt <= in_cnt + 1;
    end

  // Words delivered by the ATM end
  always @(posedge core_clk)
    if (rx_valid === 1'b1)
    begin
      chk("rx", {2'b00, rx_cnt % clen() == 0, 1'b0,
        lane(pat(rx_base, rx_cnt))},
        {2'b00, rx_first, rx_par_err, lane(rx_word)});
      rx_cnt <= rx_cnt + 1;
    end

  // Cuts a hung run short
  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      err_total++;
      finish_test();
    end
  end

  // One reset with new settings, then waits for the expected traffic
  task automatic run(input row_t r, input logic [4:0] tgt, input logic room,
                     input int lim, input int nin, input int nrx);
    @(posedge core_clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    wide_mode <= r.wide;
    odd_parity <= r.odd;
    tx_base <= r.tb;
    rx_base <= r.rb;
    goal <= int'(r.n);
    tx_sent <= 0;
    rx_fed <= 0;
    in_cnt <= 0;
    rx_cnt <= 0;
    in_room <= room;
    tx_target <= tgt;
    rx_target <= tgt;
    tx_word <= {r.tb, 8'h00};
    tx_first <= 1'b1;
    tx_valid <= 1'b1;
    out_word <= {r.rb, 8'h00};
    out_first <= 1'b1;
    out_valid <= 1'b1;
    out_avail <= 1'b1;
    repeat (40) @(posedge core_clk);
    chk("reset", 20'h0000c, {16'h0000, link.cell_in_enable_n,
      link.cell_out_enable_n, tx_take, rx_valid});
    sys_rst <= 1'b0;
    for (int c = 0; c < lim; c++)
    begin
      @(posedge core_clk);
      if (nin > 0 && in_cnt == nin && rx_cnt == nrx)
        break;
    end
    chk("in_count", 20'(nin), 20'(in_cnt));
    chk("rx_count", 20'(nrx), 20'(rx_cnt));
  endtask

  initial
  begin
    foreach (rows[k])
    begin
      run(rows[k], OWN_PORT_ADDR, 1'b1, 4000, int'(rows[k].n),
        int'(rows[k].n));
    end
    run(rows[0], OWN_PORT_ADDR, 1'b0, 1500, 0, int'(rows[0].n));
    run(rows[2], 5'h07, 1'b1, 1500, 0, 0);
    finish_test();
  end
endmodule
